// ===== amfc_pkg.sv
// Shared constants for the amplifier mode, mute and fault control block.
// Assumes a single 40 MHz clock and synchronous reset.
package amfc_pkg;
  localparam int unsigned AMFC_CLK_HZ = 40_000_000;
  localparam int unsigned AMFC_SYNC_STAGES = 2;
  // Fault code field positions and values
  localparam int unsigned AMFC_CODE_LOW_POS = 0;
  localparam int unsigned AMFC_CODE_HIGH_POS = 1;
  localparam logic [1:0] AMFC_CODE_NONE = 2'h3;
  localparam logic [1:0] AMFC_CODE_PUMP_UV = 2'h2;
  localparam logic [1:0] AMFC_CODE_THERMAL = 2'h0;
  localparam logic [1:0] AMFC_CODE_RST = AMFC_CODE_NONE;
  // Level sampling for mute and shutdown toggles
  localparam logic AMFC_MUTE_N_RST = 1'b0;
  localparam logic AMFC_SHDN_N_RST = 1'b0;
  typedef enum logic [2:0] {
    AMFC_ST_OFF = 3'b001,
    AMFC_ST_RUN = 3'b010,
    AMFC_ST_FORCE = 3'b100
  } amfc_state_type;
endpackage

// ===== amfc_top.sv
// Mode select, mute, shutdown and held fault code of a mono switching amplifier.
// Assumes pins and analog detector levels arrive asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module amfc_top
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_mode_select,
  input wire logic i_mute_n,
  input wire logic i_shutdown_n,
  input wire logic i_pump_undervoltage,
  input wire logic i_thermal_fault,
  input wire logic i_headphone_supply_low,
  output logic o_main_amp_en,
  output logic o_headphone_amp_en,
  output logic o_main_amp_mute,
  output logic o_headphone_amp_mute,
  output logic o_low_side_on,
  output logic o_shutdown,
  output logic o_fault_code_low_bit_o,
  output logic o_fault_code_low_bit_oe_n,
  output logic o_fault_code_high_bit_o,
  output logic o_fault_code_high_bit_oe_n
);
  import amfc_pkg::*;

  // Two-stage synchronisers for all asynchronous levels
  localparam int unsigned NSYNC = 6;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  assign async_in = {i_headphone_supply_low, i_thermal_fault, i_pump_undervoltage,
                     i_shutdown_n, i_mute_n, i_mode_select};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge i_clk)
      begin
        if (i_srst)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= async_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  logic mode_s;
  logic mute_n_s;
  logic shdn_n_s;
  logic pump_uv_s;
  logic therm_s;
  logic hp_low_s;
  assign mode_s = sync_r[0];
  assign mute_n_s = sync_r[1];
  assign shdn_n_s = sync_r[2];
  assign pump_uv_s = sync_r[3];
  assign therm_s = sync_r[4];
  assign hp_low_s = sync_r[5];

  // Code implied by live conditions; thermal has both bits low so it wins
  function automatic logic [1:0] amfc_live_code(input logic uv, input logic th);
    if (th)
      return AMFC_CODE_THERMAL;
    else if (uv)
      return AMFC_CODE_PUMP_UV;
    else
      return AMFC_CODE_NONE;
  endfunction

  // Previous levels of mute and shutdown to spot a toggle
  logic mute_n_prev_r;
  logic shdn_n_prev_r;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      mute_n_prev_r <= AMFC_MUTE_N_RST;
      shdn_n_prev_r <= AMFC_SHDN_N_RST;
    end
    else
    begin
      mute_n_prev_r <= mute_n_s;
      shdn_n_prev_r <= shdn_n_s;
    end
  end

  logic clear_evt;
  // Any edge of mute or shutdown counts as cycling the pin
  assign clear_evt = (mute_n_s != mute_n_prev_r) || (shdn_n_s != shdn_n_prev_r);

  // Held fault code. A live fault in the clearing cycle is kept: set wins.
  logic [1:0] code_r;
  logic [1:0] code_nxt;
  logic [1:0] live_code;
  assign live_code = amfc_live_code(pump_uv_s, therm_s);
  always_comb
  begin
    if (clear_evt)
      code_nxt = live_code;
    else
      code_nxt = code_r & live_code;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      code_r <= AMFC_CODE_RST;
    else
      code_r <= code_nxt;
  end

  // Operating state
  amfc_state_type state_r;
  amfc_state_type state_nxt;
  always_comb
  begin
    case (state_r)
      // Wake straight into forcing so a live fault never sees a cycle of drive
      AMFC_ST_OFF:
        if (!shdn_n_s)
          state_nxt = AMFC_ST_OFF;
        else if (pump_uv_s || therm_s)
          state_nxt = AMFC_ST_FORCE;
        else
          state_nxt = AMFC_ST_RUN;
      AMFC_ST_RUN:
        if (!shdn_n_s)
          state_nxt = AMFC_ST_OFF;
        else if (pump_uv_s || therm_s)
          state_nxt = AMFC_ST_FORCE;
        else
          state_nxt = AMFC_ST_RUN;
      AMFC_ST_FORCE:
        if (!shdn_n_s)
          state_nxt = AMFC_ST_OFF;
        else if (!pump_uv_s && !therm_s)
          state_nxt = AMFC_ST_RUN;
        else
          state_nxt = AMFC_ST_FORCE;
      default:
        state_nxt = AMFC_ST_OFF;
    endcase
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      state_r <= AMFC_ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Registered outputs, decoded from next state so they track it exactly
  logic run_nxt;
  logic force_nxt;
  assign run_nxt = (state_nxt == AMFC_ST_RUN);
  assign force_nxt = (state_nxt == AMFC_ST_FORCE);
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_main_amp_en <= 1'b0;
      o_headphone_amp_en <= 1'b0;
      o_main_amp_mute <= 1'b0;
      o_headphone_amp_mute <= 1'b0;
      o_low_side_on <= 1'b0;
      o_shutdown <= 1'b1;
    end
    else
    begin
      o_shutdown <= (state_nxt == AMFC_ST_OFF);
      // Unselected amplifier sleeps; never both on
      o_main_amp_en <= run_nxt && !mode_s;
      // Headphone also drops on low supply, with no code change
      o_headphone_amp_en <= run_nxt && mode_s && !hp_low_s;
      o_main_amp_mute <= run_nxt && !mode_s && !mute_n_s;
      o_headphone_amp_mute <= run_nxt && mode_s && !mute_n_s;
      // Fault forcing grounds the load in either mode
      o_low_side_on <= force_nxt || (run_nxt && !mode_s && !mute_n_s);
    end
  end

  // Open drain: enable low pulls pin low; output data held at zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_fault_code_low_bit_o <= 1'b0;
      o_fault_code_high_bit_o <= 1'b0;
      o_fault_code_low_bit_oe_n <= 1'b1;
      o_fault_code_high_bit_oe_n <= 1'b1;
    end
    else
    begin
      o_fault_code_low_bit_o <= 1'b0;
      o_fault_code_high_bit_o <= 1'b0;
      o_fault_code_low_bit_oe_n <= code_nxt[AMFC_CODE_LOW_POS];
      o_fault_code_high_bit_oe_n <= code_nxt[AMFC_CODE_HIGH_POS];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_quiet;
    !clear_evt && !pump_uv_s && !therm_s;
  endsequence

  AST_ONE_AMP: assert property (!(o_main_amp_en && o_headphone_amp_en))
    else $error("both amplifiers enabled");
  AST_MODE_MAIN: assert property (state_nxt == AMFC_ST_RUN && !mode_s |=> o_main_amp_en)
    else $error("main amp not enabled in main mode");
  AST_MUTE_GROUND: assert property (o_main_amp_mute |-> o_low_side_on)
    else $error("muted main amp without low-side on");
  AST_MUTE: assert property (run_nxt && !mute_n_s |=> o_main_amp_mute || o_headphone_amp_mute)
    else $error("mute not applied");
  AST_SHDN: assert property (!shdn_n_s |=> o_shutdown && !o_main_amp_en && !o_headphone_amp_en)
    else $error("shutdown not entered");
  AST_THERM: assert property (
    therm_s && shdn_n_s |=> o_low_side_on
    && !o_fault_code_low_bit_oe_n && !o_fault_code_high_bit_oe_n)
    else $error("thermal fault not forced or reported");
  AST_UV: assert property (
    pump_uv_s && !therm_s && shdn_n_s && code_r == AMFC_CODE_NONE
    |=> !o_fault_code_low_bit_oe_n && o_fault_code_high_bit_oe_n)
    else $error("pump fault code wrong");
  AST_HOLD: assert property (code_r != AMFC_CODE_NONE ##0 s_quiet |=> $stable(code_r))
    else $error("held code changed without toggle");
  AST_HP_LOW: assert property (hp_low_s |=> !o_headphone_amp_en)
    else $error("headphone enabled on low supply");
  // Quiet must hold in the same cycle, since the pins follow the next code
  AST_NOFAULT: assert property (
    code_r == AMFC_CODE_NONE ##0 s_quiet |=>
    o_fault_code_low_bit_oe_n && o_fault_code_high_bit_oe_n)
    else $error("fault reported with none present");
endmodule
`default_nettype wire

// ===== amfc_host_model.sv
// Host side of the fault code pins: pull-ups on the two open-drain lines.
// Assumes the design's enable is low while it pulls a line low.
`timescale 1ns/1ps
`default_nettype none
module amfc_host_model
(
  input wire logic i_low_o,
  input wire logic i_low_oe_n,
  input wire logic i_high_o,
  input wire logic i_high_oe_n,
  output var logic o_fault_code_low_bit,
  output var logic o_fault_code_high_bit
);
  // Released line reads one through its pull-up
  always_comb o_fault_code_low_bit = i_low_oe_n ? 1'b1 : i_low_o;
  always_comb o_fault_code_high_bit = i_high_oe_n ? 1'b1 : i_high_o;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the mode, mute and fault control block.
// Assumes amfc_pkg and amfc_top are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import amfc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mode = 1'b0;
  logic mute_n = 1'b1;
  logic shdn_n = 1'b1;
  logic uv = 1'b0;
  logic th = 1'b0;
  logic hpl = 1'b0;
  logic main_en, hp_en, main_mute, hp_mute, low_side, shdn;
  logic lo_o, lo_oe_n, hi_o, hi_oe_n, pin_lo, pin_hi;
  int mismatches = 0;
  int comparisons = 0;
  amfc_top u_amfc_top (.i_clk(clk), .i_srst(srst), .i_mode_select(mode), .i_mute_n(mute_n),
    .i_shutdown_n(shdn_n), .i_pump_undervoltage(uv), .i_thermal_fault(th),
    .i_headphone_supply_low(hpl), .o_main_amp_en(main_en), .o_headphone_amp_en(hp_en),
    .o_main_amp_mute(main_mute), .o_headphone_amp_mute(hp_mute), .o_low_side_on(low_side),
    .o_shutdown(shdn), .o_fault_code_low_bit_o(lo_o), .o_fault_code_low_bit_oe_n(lo_oe_n),
    .o_fault_code_high_bit_o(hi_o), .o_fault_code_high_bit_oe_n(hi_oe_n));
  amfc_host_model u_amfc_host_model (.i_low_o(lo_o), .i_low_oe_n(lo_oe_n), .i_high_o(hi_o),
    .i_high_oe_n(hi_oe_n), .o_fault_code_low_bit(pin_lo), .o_fault_code_high_bit(pin_hi));
  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %0t seen %b expected %b", $time, seen, exp);
      mismatches++;
    end
  endtask
  // Pins {mode, mute_n, shutdown_n, pump, thermal, supply low}; 3-edge answer plus margin
  task automatic drive(input logic [5:0] v);
    @(posedge clk);
    #2;
    {mode, mute_n, shdn_n, uv, th, hpl} = v;
    repeat (4) @(posedge clk);
    #2;
  endtask
  task automatic t_normal();
    drive(6'h18);
    chk({main_en, hp_en, low_side, shdn}, 4'h8);
    chk({pin_hi, pin_lo, main_mute, hp_mute}, 4'hC);
  endtask
  task automatic t_headphone();
    drive(6'h38);
    chk({main_en, hp_en, low_side, shdn}, 4'h4);
    drive(6'h39);
    chk({hp_en, pin_hi, pin_lo, shdn}, 4'h6);
    drive(6'h28);
    chk({hp_mute, low_side, main_mute, shdn}, 4'h8);
  endtask
  task automatic t_mute_main();
    drive(6'h08);
    chk({main_mute, low_side, hp_mute, shdn}, 4'hC);
  endtask
  task automatic t_pump();
    drive(6'h1C);
    chk({pin_hi, pin_lo, low_side, shdn}, 4'hA);
    drive(6'h18);
    chk({pin_hi, pin_lo, low_side, main_en}, 4'h9);
    // Host clears the held code by cycling mute
    drive(6'h08);
    drive(6'h18);
    chk({pin_hi, pin_lo, low_side, main_en}, 4'hD);
  endtask
  task automatic t_thermal();
    drive(6'h3A);
    chk({pin_hi, pin_lo, low_side, hp_en}, 4'h2);
    drive(6'h38);
    chk({pin_hi, pin_lo, low_side, hp_en}, 4'h1);
    drive(6'h30);
    chk({shdn, main_en, hp_en, low_side}, 4'h8);
    drive(6'h38);
    chk({pin_hi, pin_lo, shdn, hp_en}, 4'hD);
  endtask
  task automatic t_both();
    drive(6'h1E);
    chk({pin_hi, pin_lo, low_side, shdn}, 4'h2);
  endtask
  // Faults gone but code held; only a pulse of the synchronous reset srst clears it here
  task automatic t_reset();
    drive(6'h18);
    chk({pin_hi, pin_lo, low_side, main_en}, 4'h1);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    chk({main_en, hp_en, low_side, shdn}, 4'h1);
    chk({pin_hi, pin_lo, main_mute, hp_mute}, 4'hC);
    srst = 1'b0;
    drive(6'h18);
    chk({pin_hi, pin_lo, main_en, shdn}, 4'hE);
  endtask
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #2;
    srst = 1'b0;
    t_normal();
    t_headphone();
    t_mute_main();
    t_pump();
    t_thermal();
    t_both();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
